// >>> logic/gpw_pkg.sv
// What this block does
// - Port B: three pins, bits 2:0 active
// - Port C: eight pins, all bits active
// - Direction 0 input, 1 output
// - Data read returns sampled pad levels
// - Data write selects drive or pull
// - Latch view returns last written data
// - Port B 1:0 feed external interrupts
// - Port C carries segments 31 to 24
// - Segment select: 0 I/O, 1 segment
// - Strobe enable bit per pin
// - Wake enable bit per pin
// - Port C 6:4 converter out, 7 in
// - Converter enable forces pin directions
// - Converter port bits enable outputs
// - Attribute, direction, data select pin mode
// - Sleep level change on waked input pin wakes
// - After reset all pins are inputs
package gpw_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_B_DIR = 8'h00;
  localparam logic [7:0] OFF_C_DIR = 8'h01;
  localparam logic [7:0] OFF_B_ATT = 8'h04;
  localparam logic [7:0] OFF_C_ATT = 8'h05;
  localparam logic [7:0] OFF_B_DAT = 8'h08;
  localparam logic [7:0] OFF_C_DAT = 8'h09;
  localparam logic [7:0] OFF_B_BUF = 8'h0D;
  localparam logic [7:0] OFF_C_BUF = 8'h0E;
  localparam logic [7:0] OFF_CONV = 8'h1E;
  localparam logic [7:0] OFF_B_STB = 8'h2D;
  localparam logic [7:0] OFF_C_STB = 8'h2E;
  localparam logic [7:0] OFF_B_WAKE = 8'h37;
  localparam logic [7:0] OFF_C_WAKE = 8'h38;
  localparam logic [7:0] OFF_C_SEL = 8'h4C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h50;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h51;
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [7:0] B_MASK = 8'h07;
  localparam logic [7:0] CONV_MASK = 8'h0F;
  localparam int CONV_EN_BIT = 3;
  localparam int CONV_PIN_BASE = 4;
  localparam int CONV_IN_PIN = 7;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_EXT0_BIT = 1;
  localparam int IRQ_EXT1_BIT = 2;
  localparam logic [7:0] IRQ_MASK_BITS = 8'h07;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } gpw_bus_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } gpw_pad_type;
endpackage : gpw_pkg

// >>> logic/gpw_top.sv
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module gpw_top (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire gpw_pkg::gpw_bus_type bus,
  output logic [7:0] rdata,
  input wire logic [2:0] pb_in,
  input wire logic [7:0] pc_in,
  output gpw_pkg::gpw_pad_type pb_pad,
  output gpw_pkg::gpw_pad_type pc_pad,
  input wire logic [7:0] seg_in,
  input wire logic [2:0] conv_out_in,
  input wire logic sleep,
  output logic conv_in_out,
  output logic [1:0] ext_int,
  output logic [2:0] pb_strobe_en,
  output logic [7:0] pc_strobe_en,
  output logic wake_req,
  output logic irq
);
  import gpw_pkg::*;

  logic [7:0] b_dir_q;
  logic [7:0] b_dir_d;
  logic [7:0] c_dir_q;
  logic [7:0] c_dir_d;
  logic [7:0] b_att_q;
  logic [7:0] b_att_d;
  logic [7:0] c_att_q;
  logic [7:0] c_att_d;
  logic [7:0] b_dat_q;
  logic [7:0] b_dat_d;
  logic [7:0] c_dat_q;
  logic [7:0] c_dat_d;
  logic [7:0] conv_q;
  logic [7:0] conv_d;
  logic [7:0] b_stb_q;
  logic [7:0] b_stb_d;
  logic [7:0] c_stb_q;
  logic [7:0] c_stb_d;
  logic [7:0] b_wk_q;
  logic [7:0] b_wk_d;
  logic [7:0] c_wk_q;
  logic [7:0] c_wk_d;
  logic [7:0] c_sel_q;
  logic [7:0] c_sel_d;
  logic [7:0] stat_q;
  logic [7:0] stat_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] b_s1_q, b_s2_q, c_s1_q, c_s2_q, b_prev_q, c_prev_q;
  logic [7:0] pb_in8, pc_in8, ev;
  gpw_pad_type pb_d, pc_d, pb_q, pc_q;
  logic wake_d, wake_q, irq_d, irq_q, conv_in_d, conv_in_q;
  logic [1:0] ext_d, ext_q;

  assign pb_in8 = {5'h00, pb_in};
  assign pc_in8 = pc_in;

  // Register writes and event capture
  always_comb begin
    b_dir_d = b_dir_q;
    c_dir_d = c_dir_q;
    b_att_d = b_att_q;
    c_att_d = c_att_q;
    b_dat_d = b_dat_q;
    c_dat_d = c_dat_q;
    conv_d = conv_q;
    b_stb_d = b_stb_q;
    c_stb_d = c_stb_q;
    b_wk_d = b_wk_q;
    c_wk_d = c_wk_q;
    c_sel_d = c_sel_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (bus.wr) begin
      if (bus.addr == OFF_B_DIR) begin
        b_dir_d = bus.wdata & B_MASK;
      end else if (bus.addr == OFF_C_DIR) begin
        c_dir_d = bus.wdata;
      end else if (bus.addr == OFF_B_ATT) begin
        b_att_d = bus.wdata & B_MASK;
      end else if (bus.addr == OFF_C_ATT) begin
        c_att_d = bus.wdata;
      end else if (bus.addr == OFF_B_DAT) begin
        b_dat_d = bus.wdata & B_MASK;
      end else if (bus.addr == OFF_C_DAT) begin
        c_dat_d = bus.wdata;
      end else if (bus.addr == OFF_CONV) begin
        conv_d = bus.wdata & CONV_MASK;
      end else if (bus.addr == OFF_B_STB) begin
        b_stb_d = bus.wdata & B_MASK;
      end else if (bus.addr == OFF_C_STB) begin
        c_stb_d = bus.wdata;
      end else if (bus.addr == OFF_B_WAKE) begin
        b_wk_d = bus.wdata & B_MASK;
      end else if (bus.addr == OFF_C_WAKE) begin
        c_wk_d = bus.wdata;
      end else if (bus.addr == OFF_C_SEL) begin
        c_sel_d = bus.wdata;
      end else if (bus.addr == OFF_IRQ_MASK) begin
        mask_d = bus.wdata & IRQ_MASK_BITS;
      end
    end
    if (bus.rd && bus.addr == OFF_IRQ_STAT) begin
      stat_d = 8'h00;
    end
    stat_d = stat_d | ev; // set wins over read-clear
  end

  // Events: wake change, external interrupt edges (rising)
  always_comb begin
    ev = 8'h00;
    ev[IRQ_WAKE_BIT] = wake_d;
    ev[IRQ_EXT0_BIT] = b_s2_q[0] & ~b_prev_q[0];
    ev[IRQ_EXT1_BIT] = b_s2_q[1] & ~b_prev_q[1];
  end

  // Read mux, answer in next cycle
  always_comb begin
    rdata_d = 8'h00;
    if (bus.rd) begin
      if (bus.addr == OFF_B_DIR) begin
        rdata_d = b_dir_q;
      end else if (bus.addr == OFF_C_DIR) begin
        rdata_d = c_dir_q;
      end else if (bus.addr == OFF_B_ATT) begin
        rdata_d = b_att_q;
      end else if (bus.addr == OFF_C_ATT) begin
        rdata_d = c_att_q;
      end else if (bus.addr == OFF_B_DAT) begin
        rdata_d = b_s2_q & B_MASK;
      end else if (bus.addr == OFF_C_DAT) begin
        rdata_d = c_s2_q;
      end else if (bus.addr == OFF_B_BUF) begin
        rdata_d = b_dat_q;
      end else if (bus.addr == OFF_C_BUF) begin
        rdata_d = c_dat_q;
      end else if (bus.addr == OFF_CONV) begin
        rdata_d = conv_q;
      end else if (bus.addr == OFF_B_STB) begin
        rdata_d = b_stb_q;
      end else if (bus.addr == OFF_C_STB) begin
        rdata_d = c_stb_q;
      end else if (bus.addr == OFF_B_WAKE) begin
        rdata_d = b_wk_q;
      end else if (bus.addr == OFF_C_WAKE) begin
        rdata_d = c_wk_q;
      end else if (bus.addr == OFF_C_SEL) begin
        rdata_d = c_sel_q;
      end else if (bus.addr == OFF_IRQ_STAT) begin
        rdata_d = stat_q;
      end else if (bus.addr == OFF_IRQ_MASK) begin
        rdata_d = mask_q;
      end
    end
  end

  // Pad mode from attribute, direction, data
  always_comb begin
    logic [7:0] dir_c;
    logic [7:0] out_c;
    dir_c = c_dir_q;
    out_c = c_att_q ^ c_dat_q;
    if (conv_q[CONV_EN_BIT]) begin
      dir_c[CONV_IN_PIN] = 1'b0;
      dir_c[CONV_PIN_BASE +: 3] = 3'h7;
      for (int n = 0; n < 3; n++) begin
        if (conv_q[n]) begin
          out_c[CONV_PIN_BASE + n] = conv_out_in[n];
        end
      end
    end
    pb_d.out = (b_att_q ^ b_dat_q) & B_MASK;
    pb_d.oe_n = ~(b_dir_q & B_MASK);
    pb_d.pull_up = ~b_dir_q & b_att_q & b_dat_q & B_MASK;
    pb_d.pull_down = ~b_dir_q & ~b_att_q & b_dat_q & B_MASK;
    pc_d.out = out_c;
    pc_d.oe_n = ~dir_c;
    pc_d.pull_up = ~dir_c & c_att_q & c_dat_q;
    pc_d.pull_down = ~dir_c & ~c_att_q & c_dat_q;
    for (int i = 0; i < 8; i++) begin
      if (c_sel_q[i] && !(conv_q[CONV_EN_BIT] && i >= CONV_PIN_BASE)) begin
        pc_d.out[i] = seg_in[i];
        pc_d.oe_n[i] = 1'b0;
        pc_d.pull_up[i] = 1'b0;
        pc_d.pull_down[i] = 1'b0;
      end
    end
    conv_in_d = conv_q[CONV_EN_BIT] & c_s2_q[CONV_IN_PIN];
    ext_d = b_s2_q[1:0];
    wake_d = sleep && (|(((b_s2_q ^ b_prev_q) & b_wk_q & ~b_dir_q) |
      ((c_s2_q ^ c_prev_q) & c_wk_q & ~dir_c)));
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      b_dir_q <= RESET_VAL;
      c_dir_q <= RESET_VAL;
      b_att_q <= RESET_VAL;
      c_att_q <= RESET_VAL;
      b_dat_q <= RESET_VAL;
      c_dat_q <= RESET_VAL;
      conv_q <= RESET_VAL;
      b_stb_q <= RESET_VAL;
      c_stb_q <= RESET_VAL;
      b_wk_q <= RESET_VAL;
      c_wk_q <= RESET_VAL;
      c_sel_q <= RESET_VAL;
      stat_q <= RESET_VAL;
      mask_q <= RESET_VAL;
      rdata_q <= RESET_VAL;
      b_s1_q <= RESET_VAL;
      b_s2_q <= RESET_VAL;
      c_s1_q <= RESET_VAL;
      c_s2_q <= RESET_VAL;
      b_prev_q <= RESET_VAL;
      c_prev_q <= RESET_VAL;
      pb_q <= '{out: 8'h00, oe_n: 8'hFF, pull_up: 8'h00, pull_down: 8'h00};
      pc_q <= '{out: 8'h00, oe_n: 8'hFF, pull_up: 8'h00, pull_down: 8'h00};
      wake_q <= 1'b0;
      irq_q <= 1'b0;
      conv_in_q <= 1'b0;
      ext_q <= 2'h0;
    end else begin
      b_dir_q <= b_dir_d;
      c_dir_q <= c_dir_d;
      b_att_q <= b_att_d;
      c_att_q <= c_att_d;
      b_dat_q <= b_dat_d;
      c_dat_q <= c_dat_d;
      conv_q <= conv_d;
      b_stb_q <= b_stb_d;
      c_stb_q <= c_stb_d;
      b_wk_q <= b_wk_d;
      c_wk_q <= c_wk_d;
      c_sel_q <= c_sel_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      b_s1_q <= pb_in8;
      b_s2_q <= b_s1_q;
      c_s1_q <= pc_in8;
      c_s2_q <= c_s1_q;
      b_prev_q <= b_s2_q;
      c_prev_q <= c_s2_q;
      pb_q <= pb_d;
      pc_q <= pc_d;
      wake_q <= wake_d;
      irq_q <= irq_d;
      conv_in_q <= conv_in_d;
      ext_q <= ext_d;
    end
  end

  assign rdata = rdata_q;
  assign pb_pad = pb_q;
  assign pc_pad = pc_q;
  assign conv_in_out = conv_in_q;
  assign ext_int = ext_q;
  assign pb_strobe_en = b_stb_q[2:0];
  assign pc_strobe_en = c_stb_q;
  assign wake_req = wake_q;
  assign irq = irq_q;

  property p_reserved_zero;
    @(posedge core_clk) disable iff (sys_rst) (b_dir_q[7:3] == 5'h00) && (conv_q[7:4] == 4'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_reserved_read;
    @(posedge core_clk) disable iff (sys_rst)
      (bus.rd && bus.addr == OFF_B_DIR) |=> (rdata[7:3] == 5'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved read");

  property p_conv_read;
    @(posedge core_clk) disable iff (sys_rst)
      (bus.rd && bus.addr == OFF_CONV) |=> (rdata[7:4] == 4'h0);
  endproperty
  a_conv_read: assert property (p_conv_read) else $error("converter reserved read");

  property p_b_buf_read;
    @(posedge core_clk) disable iff (sys_rst)
      (bus.rd && bus.addr == OFF_B_BUF) |=> (rdata == $past(b_dat_q));
  endproperty
  a_b_buf_read: assert property (p_b_buf_read) else $error("port b latch view");

  property p_b_pad_read;
    @(posedge core_clk) disable iff (sys_rst)
      (bus.rd && bus.addr == OFF_B_DAT) |=>
        (rdata[2:0] == $past(b_s2_q[2:0])) && (rdata[7:3] == 5'h00);
  endproperty
  a_b_pad_read: assert property (p_b_pad_read) else $error("port b pad read");

  // Direction write lands in the register, then in the pad flop
  sequence s_b_dir_wr;
    bus.wr && bus.addr == OFF_B_DIR;
  endsequence

  sequence s_c_dir_wr;
    bus.wr && bus.addr == OFF_C_DIR;
  endsequence

  property p_c_dir_write;
    @(posedge core_clk) disable iff (sys_rst)
      (s_c_dir_wr ##1 (c_sel_q == 8'h00 && !conv_q[CONV_EN_BIT])) |=>
        (pc_pad.oe_n == ~$past(bus.wdata, 2));
  endproperty
  a_c_dir_write: assert property (p_c_dir_write) else $error("port c direction");

  property p_irq_high;
    @(posedge core_clk) disable iff (sys_rst) (|(stat_q & mask_q)) |=> irq;
  endproperty
  a_irq_high: assert property (p_irq_high) else $error("irq missing");

  property p_irq_low;
    @(posedge core_clk) disable iff (sys_rst) !(|(stat_q & mask_q)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq spurious");

  property p_stat_set;
    @(posedge core_clk) disable iff (sys_rst) ev[IRQ_WAKE_BIT] |=> stat_q[IRQ_WAKE_BIT];
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("wake status lost");

  property p_ext_follow;
    @(posedge core_clk) disable iff (sys_rst) 1'b1 |=> (ext_int == $past(b_s2_q[1:0]));
  endproperty
  a_ext_follow: assert property (p_ext_follow) else $error("ext_int wrong");

  property p_conv_in_off;
    @(posedge core_clk) disable iff (sys_rst) !conv_q[CONV_EN_BIT] |=> !conv_in_out;
  endproperty
  a_conv_in_off: assert property (p_conv_in_off) else $error("converter input leaks");

  property p_strobe_write;
    @(posedge core_clk) disable iff (sys_rst)
      (bus.wr && bus.addr == OFF_C_STB) |=> (pc_strobe_en == $past(bus.wdata));
  endproperty
  a_strobe_write: assert property (p_strobe_write) else $error("strobe enable");

  property p_buf_read;
    @(posedge core_clk) disable iff (sys_rst)
      (bus.rd && bus.addr == OFF_C_BUF) |=> (rdata == $past(c_dat_q));
  endproperty
  a_buf_read: assert property (p_buf_read) else $error("latch view wrong");

  property p_pad_read;
    @(posedge core_clk) disable iff (sys_rst)
      (bus.rd && bus.addr == OFF_C_DAT) |=> (rdata == $past(c_s2_q));
  endproperty
  a_pad_read: assert property (p_pad_read) else $error("pad read wrong");

  property p_conv_force;
    @(posedge core_clk) disable iff (sys_rst)
      conv_q[CONV_EN_BIT] && !sys_rst |=> (pc_pad.oe_n[7] == 1'b1) && (pc_pad.oe_n[6:4] == 3'h0);
  endproperty
  a_conv_force: assert property (p_conv_force) else $error("converter pins not forced");

  property p_dir_write;
    @(posedge core_clk) disable iff (sys_rst)
      s_b_dir_wr |=> ##1 (pb_pad.oe_n[2:0] == ~$past(bus.wdata[2:0], 2));
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not applied");

  property p_pull_up;
    @(posedge core_clk) disable iff (sys_rst)
      (b_att_q[0] && b_dat_q[0] && !b_dir_q[0]) |=> pb_pad.pull_up[0];
  endproperty
  a_pull_up: assert property (p_pull_up) else $error("pull-up missing");

  property p_wake;
    @(posedge core_clk) disable iff (sys_rst) !sleep |=> !wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside sleep");

  property p_seg;
    @(posedge core_clk) disable iff (sys_rst)
      (c_sel_q[0] && !sys_rst) |=> (pc_pad.out[0] == $past(seg_in[0]));
  endproperty
  a_seg: assert property (p_seg) else $error("segment not routed");
endmodule : gpw_top

// >>> test/gpw_pins.sv
`timescale 1ns/1ps
module gpw_pins (
  input wire gpw_pkg::gpw_pad_type pb_pad,
  input wire gpw_pkg::gpw_pad_type pc_pad,
  input wire logic [2:0] pb_ext,
  input wire logic [7:0] pc_ext,
  output logic [2:0] pb_lvl,
  output logic [7:0] pc_lvl
);
  import gpw_pkg::*;
  logic [7:0] pb_full;

  // Driver wins, then pull resistor, then whatever the keypad side puts on the line
  function automatic logic [7:0] resolve(input gpw_pad_type p, input logic [7:0] ext);
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v[i] = !p.oe_n[i] ? p.out[i] : p.pull_up[i] ? 1'b1 : p.pull_down[i] ? 1'b0 : ext[i];
    end
    return v;
  endfunction : resolve

  always_comb begin
    pb_full = resolve(pb_pad, {5'h00, pb_ext});
    pb_lvl = pb_full[2:0];
    pc_lvl = resolve(pc_pad, pc_ext);
  end
endmodule : gpw_pins

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import gpw_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  gpw_bus_type bus = '0;
  logic [7:0] rdata;
  logic [2:0] pb_in;
  logic [7:0] pc_in;
  logic [2:0] pb_ext = 3'h0;
  logic [7:0] pc_ext = 8'h00;
  logic [7:0] seg_in = 8'h00;
  logic [2:0] conv_out_in = 3'h0;
  logic sleep = 1'b0;
  gpw_pad_type pb_pad;
  gpw_pad_type pc_pad;
  logic conv_in_out;
  logic [1:0] ext_int;
  logic [2:0] pb_strobe_en;
  logic [7:0] pc_strobe_en;
  logic wake_req;
  logic irq;
  int n_fail = 0;
  int total_checks = 0;
  logic [7:0] offs [16] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0D, 8'h0E,
    8'h1E, 8'h2D, 8'h2E, 8'h37, 8'h38, 8'h4C, 8'h50, 8'h7F};
  logic [7:0] boffs [4] = '{8'h00, 8'h04, 8'h2D, 8'h37};

  always #25 core_clk = ~core_clk;

  gpw_top gpw_top_i (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
    .pb_in(pb_in), .pc_in(pc_in), .pb_pad(pb_pad), .pc_pad(pc_pad), .seg_in(seg_in),
    .conv_out_in(conv_out_in), .sleep(sleep), .conv_in_out(conv_in_out),
    .ext_int(ext_int), .pb_strobe_en(pb_strobe_en), .pc_strobe_en(pc_strobe_en),
    .wake_req(wake_req), .irq(irq));
  gpw_pins gpw_pins_i (.pb_pad(pb_pad), .pc_pad(pc_pad), .pb_ext(pb_ext),
    .pc_ext(pc_ext), .pb_lvl(pb_in), .pc_lvl(pc_in));

  task automatic wrap_up;
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_fail++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= {a, d, 2'b10};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    bus <= {a, 8'h00, 2'b01};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd

  // Covers pad flop plus the two-flop input synchroniser
  task automatic settle;
    repeat (6) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic watch(input logic exp);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 12 && !seen; i++) begin
      @(posedge core_clk);
      #1 seen = (wake_req === 1'b1);
    end
    chk("wake_req", {7'h00, exp}, {7'h00, seen});
    if (exp && !seen) wrap_up();
  endtask : watch

  initial begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (offs[i]) rd(offs[i], 8'h00);
    chk("pc oe_n", 8'hFF, pc_pad.oe_n);
    foreach (boffs[i]) begin
      wr(boffs[i], 8'hFF);
      rd(boffs[i], 8'h07);
      wr(boffs[i], 8'h00);
    end
    wr(8'h08, 8'hFF);
    rd(8'h0D, 8'h07);
    wr(8'h08, 8'h00);
    wr(8'h1E, 8'hFF);
    rd(8'h1E, 8'h0F);
    wr(8'h1E, 8'h00);
    // Pin 2 drives low, pins 1:0 pulled high
    wr(8'h00, 8'h04);
    wr(8'h04, 8'h03);
    wr(8'h08, 8'h03);
    settle();
    chk("pb oe_n", 8'hFB, pb_pad.oe_n);
    chk("pb pull_up", 8'h03, pb_pad.pull_up);
    chk("ext_int", 8'h03, {6'h00, ext_int});
    rd(8'h08, 8'h03);
    rd(8'h50, 8'h06);
    wr(8'h08, 8'h07);
    settle();
    chk("pb out", 8'h04, pb_pad.out);
    rd(8'h08, 8'h07);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h00);
    // Pin i of port C gets mode {att,dir,dat} = i
    wr(8'h05, 8'hF0);
    wr(8'h01, 8'hCC);
    wr(8'h09, 8'hAA);
    pc_ext <= 8'h11;
    settle();
    chk("pc oe_n", 8'h33, pc_pad.oe_n);
    chk("pc pull_up", 8'h20, pc_pad.pull_up);
    chk("pc pull_down", 8'h02, pc_pad.pull_down);
    chk("pc out", 8'h48, pc_pad.out & 8'hCC);
    rd(8'h09, 8'h79);
    rd(8'h0E, 8'hAA);
    seg_in <= 8'h80;
    wr(8'h4C, 8'h81);
    settle();
    chk("seg pins", 8'h02, {4'h0, pc_pad.oe_n[7], pc_pad.oe_n[0], pc_pad.out[7],
      pc_pad.out[0]});
    wr(8'h4C, 8'h00);
    conv_out_in <= 3'b101;
    pc_ext <= 8'h91;
    wr(8'h1E, 8'h0F);
    settle();
    chk("conv oe_n", 8'h83, pc_pad.oe_n);
    chk("conv out", 8'h05, {5'h00, pc_pad.out[6:4]});
    chk("conv_in_out", 8'h01, {7'h00, conv_in_out});
    conv_out_in <= 3'b010;
    wr(8'h1E, 8'h0A);
    settle();
    chk("conv pin5", 8'h01, {7'h00, pc_pad.out[5]});
    wr(8'h1E, 8'h00);
    wr(8'h2D, 8'h05);
    wr(8'h2E, 8'hA5);
    settle();
    chk("pb_strobe_en", 8'h05, {5'h00, pb_strobe_en});
    chk("pc_strobe_en", 8'hA5, pc_strobe_en);
    wr(8'h51, 8'h01);
    wr(8'h38, 8'h01);
    settle();
    sleep <= 1'b1;
    @(posedge core_clk);
    pc_ext <= 8'h90;
    watch(1'b1);
    settle();
    chk("irq", 8'h01, {7'h00, irq});
    rd(8'h50, 8'h01);
    settle();
    chk("irq", 8'h00, {7'h00, irq});
    pc_ext <= 8'h80;
    watch(1'b0);
    sleep <= 1'b0;
    wrap_up();
  end
endmodule : tb
